// ==== rtl/apb_master_port.v ====
// One-request APB master that carries device register accesses.
`timescale 1ns/100ps
module apb_master_port (
  input  wire        clk,      // System clock.
  input  wire        resetn,   // Synchronous reset, active low.
  input  wire        req,      // One-cycle pulse: start a transfer.
  input  wire        req_write,// Direction of the requested transfer.
  input  wire [7:0]  req_addr, // Byte address of the transfer.
  input  wire [7:0]  req_wdata,// Write data, low byte.
  output reg         done,     // One-cycle pulse: transfer finished.
  output reg  [7:0]  rdata,    // Read data captured at completion.
  output reg         err,      // Error answer captured at completion.
  output reg         m_psel,   // APB select.
  output reg         m_penable,// APB enable.
  output reg         m_pwrite, // APB direction.
  output reg  [31:0] m_paddr,  // APB address.
  output reg  [31:0] m_pwdata, // APB write data.
  input  wire        m_pready, // APB ready from the device.
  input  wire [31:0] m_prdata, // APB read data from the device.
  input  wire        m_pslverr // APB error from the device.
);

////////////////////////////////////////////////////////////////////////////
// The request is held unchanged until pready is seen in the access phase.
always @(posedge clk) begin
  if (!resetn) begin
    m_psel    <= 1'b0;
    m_penable <= 1'b0;
    m_pwrite  <= 1'b0;
    m_paddr   <= 32'h0000_0000;
    m_pwdata  <= 32'h0000_0000;
    done      <= 1'b0;
    rdata     <= 8'h00;
    err       <= 1'b0;
  end else begin
    done <= 1'b0;
    if (m_psel && m_penable && m_pready) begin
      // Completion edge: take read data and release the bus.
      m_psel    <= 1'b0;
      m_penable <= 1'b0;
      done      <= 1'b1;
      rdata     <= m_prdata[7:0];
      err       <= m_pslverr;
    end else if (m_psel) begin
      // Setup cycle is over; enter the access phase.
      m_penable <= 1'b1;
    end else if (req) begin
      // Setup cycle: address, direction and data become valid.
      m_psel   <= 1'b1;
      m_pwrite <= req_write;
      m_paddr  <= {24'h00_0000, req_addr};
      m_pwdata <= {24'h00_0000, req_wdata};
    end
  end
end

endmodule // apb_master_port

// ==== rtl/supply_monitor_host.v ====
// Host controller that sets up and services two supply voltage monitors.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`include "supply_monitor_map.vh"
module supply_monitor_host #(
  parameter SETTLE_NS = 100000  // Detector enable-to-active time in ns.
) (
  input  wire        clk,        // System clock, 125 MHz.
  input  wire        resetn,     // Synchronous reset, active low.
  input  wire        s_psel,     // Software APB select.
  input  wire        s_penable,  // Software APB enable.
  input  wire        s_pwrite,   // Software APB direction.
  input  wire [31:0] s_paddr,    // Software APB address.
  input  wire [31:0] s_pwdata,   // Software APB write data.
  output reg         s_pready,   // Software APB ready.
  output reg  [31:0] s_prdata,   // Software APB read data.
  output reg         s_pslverr,  // Software APB error.
  output wire        m_psel,     // Device APB select.
  output wire        m_penable,  // Device APB enable.
  output wire        m_pwrite,   // Device APB direction.
  output wire [31:0] m_paddr,    // Device APB address.
  output wire [31:0] m_pwdata,   // Device APB write data.
  input  wire        m_pready,   // Device APB ready.
  input  wire [31:0] m_prdata,   // Device APB read data.
  input  wire        m_pslverr,  // Device APB error.
  input  wire        mon1_irq,   // Monitor one interrupt request level.
  input  wire        mon2_irq,   // Monitor two interrupt request level.
  input  wire        chip_reset_req // Device chip reset request level.
);

////////////////////////////////////////////////////////////////////////////
// Constants.

// Settle wait in clocks, rounded up to whole cycles.
localparam integer SETTLE_INT =
  (SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam integer FILT_INT = `FILT_WAIT_CYC;
// Both counts are cut to the wait counter's width on purpose.
localparam [15:0] SETTLE_CYC = SETTLE_INT[15:0];
localparam [15:0] FILT_CYC = FILT_INT[15:0];

// Sequencer states, one-hot.
localparam [3:0] S_IDLE  = 4'h1;
localparam [3:0] S_FETCH = 4'h2;
localparam [3:0] S_BUS   = 4'h4;
localparam [3:0] S_WAIT  = 4'h8;

// Kinds of sequence steps.
localparam [2:0] K_WRITE  = 3'h0;
localparam [2:0] K_READ   = 3'h1;
localparam [2:0] K_SETTLE = 3'h2;
localparam [2:0] K_FILT   = 3'h3;
localparam [2:0] K_END    = 3'h4;

////////////////////////////////////////////////////////////////////////////
// Functions.

// Assembles a monitor control byte from its fields.
function [7:0] ctl_byte;
  input       dir;
  input       act;
  input [1:0] fclk;
  input       byp;
  input       flag;
  input       arm;
  begin
    ctl_byte = 8'h00;
    ctl_byte[`MON_DIR_BIT]                 = dir;
    ctl_byte[`MON_ACTION_BIT]              = act;
    ctl_byte[`MON_FCLK_LSB+1:`MON_FCLK_LSB] = fclk;
    ctl_byte[`MON_BYPASS_BIT]              = byp;
    ctl_byte[`MON_FLAG_BIT]                = flag;
    ctl_byte[`MON_ARM_BIT]                 = arm;
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Registers and wires.

reg  [3:0]  state_r;      // Sequencer state.
reg  [3:0]  idx_r;        // Step index within the running sequence.
reg         handler_r;    // Running sequence is the crossing handler.
reg         mon_r;        // Monitor served: 0 for one, 1 for two.
reg  [7:0]  cmd_r;        // Last accepted setup command.
reg         go_r;         // Setup command waiting to start.
reg         auto_r;       // Automatic handling of crossings enabled.
reg  [1:0]  dir_r;        // Current direction of each monitor.
reg  [1:0]  act_r;        // Current action of each monitor.
reg  [1:0]  byp_r;        // Current filter bypass of each monitor.
reg  [3:0]  fclk_r;       // Filter clock select, two bits per monitor.
reg  [1:0]  det_r;        // Detectors already enabled.
reg  [1:0]  flag_r;       // Flags read back in keep mode.
reg  [1:0]  pend_r;       // Crossing interrupts awaiting the handler.
reg  [1:0]  irq_d_r;      // Previous interrupt request levels.
reg         rst_seen_r;   // Chip reset request was observed.
reg         done_r;       // Last sequence finished.
reg         err_r;        // Device answered a transfer with an error.
reg  [15:0] cnt_r;        // Wait counter.
reg  [7:0]  hcount_r;     // Handler runs completed.
reg         req_r;        // Transfer request pulse to the master port.
reg         req_wr_r;     // Direction of the transfer request.
reg  [7:0]  req_addr_r;   // Address of the transfer request.
reg  [7:0]  req_data_r;   // Data of the transfer request.
reg  [2:0]  op_kind;      // Decoded kind of the current step.
reg  [7:0]  op_addr;      // Decoded address of the current step.
reg  [7:0]  op_data;      // Decoded data of the current step.
wire        m_done;       // Transfer finished pulse.
wire [7:0]  m_rdata;      // Captured device read data.
wire        m_err;        // Captured device error answer.
wire        s_acc;        // Software access phase, first cycle.
wire        s_wr;         // Software write takes effect.
wire [1:0]  irq_rise;     // Rising edge of each interrupt request.
wire [7:0]  mon_addr;     // Control register of the served monitor.
wire        cur_dir;      // Direction of the served monitor.
wire        cur_act;      // Action of the served monitor.
wire        cur_byp;      // Bypass of the served monitor.
wire [1:0]  cur_fclk;     // Filter clock of the served monitor.

assign s_acc    = s_psel && s_penable && !s_pready;
assign s_wr     = s_acc && s_pwrite;
assign irq_rise = {mon2_irq, mon1_irq} & ~irq_d_r;
assign mon_addr = mon_r ? `DEV_MON_TWO : `DEV_MON_ONE;
assign cur_dir  = dir_r[mon_r];
assign cur_act  = act_r[mon_r];
assign cur_byp  = byp_r[mon_r];
assign cur_fclk = mon_r ? fclk_r[3:2] : fclk_r[1:0];

////////////////////////////////////////////////////////////////////////////
// Step decoder: what each step of the running sequence does.
always @* begin
  op_kind = K_END;
  op_addr = `DEV_WRITE_PROTECT;
  op_data = 8'h00;
  if (!handler_r) begin
    case (idx_r)
      4'd0: begin
        // Open the protect gate for the monitor registers.
        op_kind = K_WRITE;
        op_data[`UNLOCK_BIT] = 1'b1;
      end
      4'd1: begin
        op_kind = K_WRITE;
        op_addr = `DEV_MON_ENABLE;
        op_data[`SHARED_EN_BIT] = 1'b1;
      end
      4'd2: begin
        op_kind = K_WRITE;
        op_addr = `DEV_DETECTOR_CTRL;
        op_data[`DET1_EN_BIT] = det_r[0] | !mon_r;
        op_data[`DET2_EN_BIT] = det_r[1] | mon_r;
      end
      4'd3: begin
        op_kind = K_SETTLE;
      end
      4'd4: begin
        // All four selections (direction, action, filter clock, bypass) go in one store while disarmed.
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b1, 1'b0);
      end
      4'd5: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b0, 1'b0);
      end
      4'd6: begin
        // Whole clock mode byte written with the stop bit low.
        op_kind = K_WRITE;
        op_addr = `DEV_CLOCK_MODE;
        op_data[`OSC_STOP_BIT] = 1'b0;
      end
      4'd7: begin
        op_kind = cur_byp ? K_READ : K_FILT;
        op_addr = mon_addr;
        if (cur_byp) begin
          // No wait needed: a harmless read stands in for it.
          op_kind = K_READ;
        end
      end
      4'd8: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b1, 1'b1);
      end
      4'd9: begin
        op_addr = mon_addr;
        if (cmd_r[`CMD_KEEP_BIT]) begin
          op_kind = K_READ;
        end else begin
          op_kind = K_WRITE;
          op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                             1'b0, 1'b1);
        end
      end
      4'd10: begin
        op_kind = K_WRITE;
      end
      default: begin
        op_kind = K_END;
      end
    endcase
  end else begin
    // Crossing handler; dir_r already holds the flipped direction.
    case (idx_r)
      4'd0: begin
        op_kind = K_WRITE;
        op_data[`UNLOCK_BIT] = 1'b1;
      end
      4'd1: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(!cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b1, 1'b0);
      end
      4'd2: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b1, 1'b0);
      end
      4'd3: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b0, 1'b0);
      end
      4'd4: begin
        op_kind = K_WRITE;
        op_addr = mon_addr;
        op_data = ctl_byte(cur_dir, cur_act, cur_fclk, cur_byp,
                           1'b0, 1'b1);
      end
      4'd5: begin
        op_kind = K_WRITE;
      end
      default: begin
        op_kind = K_END;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Sequencer: issues steps, waits, and starts setups or handler runs.
always @(posedge clk) begin
  if (!resetn) begin
    state_r    <= S_IDLE;
    idx_r      <= 4'h0;
    handler_r  <= 1'b0;
    mon_r      <= 1'b0;
    dir_r      <= 2'b00;
    act_r      <= 2'b00;
    byp_r      <= 2'b00;
    fclk_r     <= 4'h0;
    det_r      <= 2'b00;
    flag_r     <= 2'b00;
    done_r     <= 1'b0;
    err_r      <= 1'b0;
    cnt_r      <= 16'h0000;
    hcount_r   <= 8'h00;
    req_r      <= 1'b0;
    req_wr_r   <= 1'b0;
    req_addr_r <= 8'h00;
    req_data_r <= 8'h00;
  end else begin
    req_r <= 1'b0;
    case (state_r)
      S_IDLE: begin
        if (auto_r && pend_r != 2'b00) begin
          // A crossing waits: serve monitor one first, flip direction.
          mon_r     <= !pend_r[0];
          handler_r <= 1'b1;
          idx_r     <= 4'h0;
          done_r    <= 1'b0;
          if (pend_r[0]) begin
            dir_r[0] <= !dir_r[0];
          end else begin
            dir_r[1] <= !dir_r[1];
          end
          state_r <= S_FETCH;
        end else if (go_r) begin
          // Capture the command fields for the chosen monitor.
          mon_r     <= cmd_r[`CMD_MON_BIT];
          handler_r <= 1'b0;
          idx_r     <= 4'h0;
          done_r    <= 1'b0;
          dir_r[cmd_r[`CMD_MON_BIT]] <= cmd_r[`CMD_DIR_BIT] |
                                        cmd_r[`CMD_ACTION_BIT];
          act_r[cmd_r[`CMD_MON_BIT]] <= cmd_r[`CMD_ACTION_BIT];
          byp_r[cmd_r[`CMD_MON_BIT]] <= cmd_r[`CMD_BYPASS_BIT];
          if (cmd_r[`CMD_MON_BIT]) begin
            fclk_r[3:2] <= cmd_r[`CMD_FCLK_LSB+1:`CMD_FCLK_LSB];
          end else begin
            fclk_r[1:0] <= cmd_r[`CMD_FCLK_LSB+1:`CMD_FCLK_LSB];
          end
          state_r <= S_FETCH;
        end
      end
      S_FETCH: begin
        if (op_kind == K_WRITE || op_kind == K_READ) begin
          req_r      <= 1'b1;
          req_wr_r   <= (op_kind == K_WRITE);
          req_addr_r <= op_addr;
          req_data_r <= op_data;
          state_r    <= S_BUS;
        end else if (op_kind == K_SETTLE) begin
          cnt_r   <= SETTLE_CYC;
          state_r <= S_WAIT;
        end else if (op_kind == K_FILT) begin
          cnt_r   <= FILT_CYC;
          state_r <= S_WAIT;
        end else begin
          // End of sequence.
          if (handler_r) begin
            hcount_r <= hcount_r + 8'h01;
          end else begin
            det_r[mon_r] <= 1'b1;
          end
          done_r  <= 1'b1;
          state_r <= S_IDLE;
        end
      end
      S_BUS: begin
        if (m_done) begin
          if (m_err) begin
            err_r <= 1'b1;
          end
          if (!handler_r && idx_r == 4'd9 && !req_wr_r) begin
            flag_r[mon_r] <= m_rdata[`MON_FLAG_BIT];
          end
          idx_r   <= idx_r + 4'h1;
          state_r <= S_FETCH;
        end
      end
      S_WAIT: begin
        if (cnt_r <= 16'h0001) begin
          idx_r   <= idx_r + 4'h1;
          state_r <= S_FETCH;
        end else begin
          cnt_r <= cnt_r - 16'h0001;
        end
      end
      default: begin
        state_r <= S_IDLE;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////
// Software registers, event capture and the software APB answer.
always @(posedge clk) begin
  if (!resetn) begin
    cmd_r      <= 8'h00;
    go_r       <= 1'b0;
    auto_r     <= 1'b0;
    pend_r     <= 2'b00;
    irq_d_r    <= 2'b00;
    rst_seen_r <= 1'b0;
    s_pready   <= 1'b0;
    s_prdata   <= 32'h0000_0000;
    s_pslverr  <= 1'b0;
  end else begin
    irq_d_r  <= {mon2_irq, mon1_irq};
    s_pready <= s_acc;
    // Crossings from armed interrupt monitors queue a handler run.
    if (state_r == S_IDLE && auto_r && pend_r != 2'b00) begin
      // Only the served monitor's pending bit is dropped; new rises win.
      pend_r <= (pend_r & {pend_r[0], !pend_r[0]}) | irq_rise;
    end else begin
      pend_r <= pend_r | irq_rise;
    end
    if (state_r == S_IDLE && go_r && !(auto_r && pend_r != 2'b00)) begin
      go_r <= 1'b0;
    end
    // Reset request: write 1 clears, but a new request wins.
    if (chip_reset_req) begin
      rst_seen_r <= 1'b1;
    end else if (s_wr && s_paddr[7:0] == `REG_STATUS &&
                 s_pwdata[`ST_RESET_BIT]) begin
      rst_seen_r <= 1'b0;
    end
    if (s_wr && s_paddr[7:0] == `REG_COMMAND &&
        s_pwdata[`CMD_GO_BIT] && !go_r && state_r == S_IDLE) begin
      // Commands arriving while busy are ignored.
      cmd_r <= s_pwdata[7:0];
      go_r  <= 1'b1;
    end
    if (s_wr && s_paddr[7:0] == `REG_AUTO) begin
      auto_r <= s_pwdata[0];
    end
    if (s_acc) begin
      s_pslverr <= 1'b0;
      s_prdata  <= 32'h0000_0000;
      case (s_paddr[7:0])
        `REG_COMMAND: s_prdata <= {24'h00_0000, cmd_r};
        `REG_AUTO:    s_prdata <= {31'h0000_0000, auto_r};
        `REG_STATUS: begin
          s_prdata <= {24'h00_0000, err_r, rst_seen_r, dir_r, flag_r,
                       done_r, (state_r != S_IDLE) | go_r};
        end
        `REG_COUNT:   s_prdata <= {24'h00_0000, hcount_r};
        default:      s_pslverr <= 1'b1;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Downstream port to the device registers.
apb_master_port u_port (
  .clk       (clk),
  .resetn    (resetn),
  .req       (req_r),
  .req_write (req_wr_r),
  .req_addr  (req_addr_r),
  .req_wdata (req_data_r),
  .done      (m_done),
  .rdata     (m_rdata),
  .err       (m_err),
  .m_psel    (m_psel),
  .m_penable (m_penable),
  .m_pwrite  (m_pwrite),
  .m_paddr   (m_paddr),
  .m_pwdata  (m_pwdata),
  .m_pready  (m_pready),
  .m_prdata  (m_prdata),
  .m_pslverr (m_pslverr)
);

endmodule // supply_monitor_host

// ==== rtl/supply_monitor_map.vh ====
// Offsets, field positions and timing counts of the supply monitor host.
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// Timing: system clock period and filter sampling clock.
`define CLK_PERIOD_NS     8
`define FILT_CLK_KHZ      125
`define FILT_WAIT_SAMPLES 3
// Filter wait in clocks: three sampling periods, rounded up.
`define FILT_WAIT_CYC ((`FILT_WAIT_SAMPLES * 1000000 + `FILT_CLK_KHZ * \
  `CLK_PERIOD_NS - 1) / (`FILT_CLK_KHZ * `CLK_PERIOD_NS))

// Device register byte offsets on the downstream port.
`define DEV_WRITE_PROTECT 8'h00
`define DEV_MON_ENABLE    8'h04
`define DEV_DETECTOR_CTRL 8'h08
`define DEV_CLOCK_MODE    8'h0C
`define DEV_MON_ONE       8'h10
`define DEV_MON_TWO       8'h14

// Device register field positions.
`define UNLOCK_BIT        3
`define SHARED_EN_BIT     7
`define DET1_EN_BIT       6
`define DET2_EN_BIT       7
`define OSC_STOP_BIT      4
`define MON_ARM_BIT       0
`define MON_BYPASS_BIT    1
`define MON_FLAG_BIT      2
`define MON_FCLK_LSB      4
`define MON_ACTION_BIT    6
`define MON_DIR_BIT       7

// Own register byte offsets on the software port.
`define REG_COMMAND       8'h00
`define REG_AUTO          8'h04
`define REG_STATUS        8'h08
`define REG_COUNT         8'h0C

// Command register fields.
`define CMD_GO_BIT        0
`define CMD_MON_BIT       1
`define CMD_DIR_BIT       2
`define CMD_BYPASS_BIT    3
`define CMD_ACTION_BIT    4
`define CMD_FCLK_LSB      5
`define CMD_KEEP_BIT      7

// Status register fields.
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_FLAG1_BIT      2
`define ST_FLAG2_BIT      3
`define ST_DIR1_BIT       4
`define ST_DIR2_BIT       5
`define ST_RESET_BIT      6
`define ST_ERR_BIT        7

`endif

// ==== sim/supply_device_model.sv ====
// Behavioural model of the supply monitor device registers.
`timescale 1ns/100ps
module supply_device_model (
  input  wire logic        clk,     // Clock.
  input  wire logic        resetn,  // Reset.
  input  wire logic        psel,    // Select.
  input  wire logic        penable, // Enable.
  input  wire logic        pwrite,  // Direction.
  input  wire logic [31:0] paddr,   // Address.
  input  wire logic [31:0] pwdata,  // Write data.
  output logic             pready,  // Ready.
  output logic      [31:0] prdata,  // Read data.
  output wire logic        pslverr, // Error.
  input  wire logic        cross1,  // Crossing seen by monitor one.
  input  wire logic        cross2,  // Crossing seen by monitor two.
  output wire logic        irq1,    // Interrupt one.
  output wire logic        irq2,    // Interrupt two.
  output wire logic        rst_req  // Chip reset request.
);
  logic [7:0] prot_r, en_r, det_r, osc_r, mon1_r, mon2_r;
  logic       pend1_r, pend2_r;
  logic [1:0] wait_r;
  wire  [7:0] a_w = paddr[7:0];
  wire  [7:0] d_w = pwdata[7:0];
  wire  [7:0] rd_w = a_w == 8'h10 ? mon1_r : a_w == 8'h14 ? mon2_r :
                     a_w == 8'h00 ? prot_r : 8'h00;
  assign pslverr = 1'b0;
  // Only a crossing seen while armed may interrupt or reset.
  assign irq1 = pend1_r && mon1_r[0] && !mon1_r[6];
  assign irq2 = pend2_r && mon2_r[0] && !mon2_r[6];
  assign rst_req = (pend1_r && mon1_r[0] && mon1_r[6]) ||
                   (pend2_r && mon2_r[0] && mon2_r[6]);
  // Random wait states; read data scrambles when idle.
  always @(posedge clk) begin
    pready <= 1'b0;
    prdata <= ~prdata;
    if (!resetn) begin
      {prot_r, en_r, det_r, mon1_r, mon2_r} <= '0;
      osc_r <= 8'h10;
      {pend1_r, pend2_r, wait_r} <= '0;
    end else begin
      if (cross1) begin
        mon1_r[2] <= 1'b1;
        pend1_r <= pend1_r | mon1_r[0];
      end
      if (cross2) begin
        mon2_r[2] <= 1'b1;
        pend2_r <= pend2_r | mon2_r[0];
      end
      if (psel && penable && !pready) begin
        if (wait_r == 2'd0) begin
          pready <= 1'b1;
          prdata <= {24'h0, rd_w};
          wait_r <= 2'($urandom % 3);
        end else
          wait_r <= wait_r - 2'd1;
      end
      // Writes beyond the protect register need the unlock bit.
      if (psel && penable && pready && pwrite && (prot_r[3] || a_w == 0)) begin
        case (a_w)
          8'h00: prot_r <= d_w;
          8'h04: en_r <= d_w;
          8'h08: det_r <= d_w;
          8'h0C: osc_r <= d_w;
          8'h10: begin
            mon1_r <= {d_w[7:3], d_w[2] & mon1_r[2], d_w[1:0]};
            if (!d_w[2]) pend1_r <= 1'b0;
          end
          8'h14: begin
            mon2_r <= {d_w[7:3], d_w[2] & mon2_r[2], d_w[1:0]};
            if (!d_w[2]) pend2_r <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // supply_device_model

// ==== sim/supply_monitor_host_monitor.sv ====
// Checker of the supply monitor host ports.
`timescale 1ns/100ps
module supply_monitor_host_monitor (
  input wire logic        clk,       // Clock.
  input wire logic        resetn,    // Reset.
  input wire logic        s_psel,    // Select.
  input wire logic        s_penable, // Enable.
  input wire logic        s_pready,  // Ready.
  input wire logic        s_pslverr, // Error.
  input wire logic [31:0] s_prdata,  // Read data.
  input wire logic        m_psel,    // Select.
  input wire logic        m_penable, // Enable.
  input wire logic        m_pwrite,  // Direction.
  input wire logic [31:0] m_paddr,   // Address.
  input wire logic [31:0] m_pwdata,  // Write data.
  input wire logic        m_pready   // Ready.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Phases of one device transfer.
  sequence setup_s; m_psel && !m_penable; endsequence
  sequence stall_s; m_psel && m_penable && !m_pready; endsequence
  sequence end_s; m_psel && m_penable && m_pready; endsequence
  sw_wait_a: assert property (s_psel && s_penable && !s_pready |=> s_pready)
    else $error("software answer late");
  sw_pulse_a: assert property (s_pready |=> !s_pready)
    else $error("software ready too long");
  err_data_a: assert property (s_pready && s_pslverr |-> s_prdata == 32'h0)
    else $error("error answer carries data");
  dev_access_a: assert property (setup_s |=> m_psel && m_penable)
    else $error("no access phase after setup");
  dev_hold_a: assert property (stall_s |=> $stable(m_paddr) &&
    $stable(m_pwdata) && $stable(m_pwrite)) else $error("request moved");
  dev_release_a: assert property (end_s |=> !m_psel && !m_penable)
    else $error("device request not released");
  byte_data_a: assert property (m_psel && m_pwrite |-> m_pwdata[31:8] == 24'h0)
    else $error("upper write bits set");
  reset_falling_a: assert property (m_psel && m_pwrite && m_pwdata[6] &&
    (m_paddr[7:0] == 8'h10 || m_paddr[7:0] == 8'h14) |-> m_pwdata[7])
    else $error("reset mode without falling direction");
endmodule // supply_monitor_host_monitor
bind supply_monitor_host supply_monitor_host_monitor u_chk (.clk, .resetn,
  .s_psel, .s_penable, .s_pready, .s_pslverr, .s_prdata, .m_psel,
  .m_penable, .m_pwrite, .m_paddr, .m_pwdata, .m_pready);

// ==== sim/supply_monitor_host_tb.sv ====
// Self-checking bench of the supply monitor host.
`timescale 1ns/100ps
module supply_monitor_host_tb;
  logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, x1 = 0, x2 = 0;
  logic [31:0] paddr = 0, pwdata = 0, rd, s_prdata, m_paddr, m_pwdata, m_prdata;
  logic s_pready, s_pslverr, m_psel, m_penable, m_pwrite, m_pready, m_pslverr;
  logic irq1, irq2, rreq, er, d1;
  int n_mismatch = 0, total_checks = 0, cyc = 0, n;
  always #4 clk = ~clk;
  supply_monitor_host #(.SETTLE_NS(80)) u_dut (.clk, .resetn, .s_psel(psel),
    .s_penable(penable), .s_pwrite(pwrite), .s_paddr(paddr),
    .s_pwdata(pwdata), .s_pready, .s_prdata, .s_pslverr, .m_psel, .m_penable,
    .m_pwrite, .m_paddr, .m_pwdata, .m_pready, .m_prdata, .m_pslverr,
    .mon1_irq(irq1), .mon2_irq(irq2), .chip_reset_req(rreq));
  supply_device_model u_dev (.clk, .resetn, .psel(m_psel), .penable(m_penable),
    .pwrite(m_pwrite), .paddr(m_paddr), .pwdata(m_pwdata), .pready(m_pready),
    .prdata(m_prdata), .pslverr(m_pslverr), .cross1(x1), .cross2(x2), .irq1,
    .irq2, .rst_req(rreq));
  function automatic logic [31:0] cmd(logic m, dr, b, ac, k);
    return {24'h0, k, 2'b00, ac, b, dr, m, 1'b1};
  endfunction
  function automatic logic [31:0] mreg(logic dr, ac, b, f, ar);
    return {24'h0, dr, ac, 3'b000, f, b, ar};
  endfunction
  task automatic chk(input logic [32:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One software transfer; the bench timeout bounds the wait for ready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (s_pready !== 1'b1);
    rd = s_prdata;
    er = s_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start a setup and poll status until it is no longer busy.
  task automatic run(input logic [31:0] c);
    apb(1, 8'h00, c);
    do begin
      apb(0, 8'h08, 0);
    end while (rd[0] !== 1'b0);
  endtask
  task automatic pulse(input logic two);
    @(posedge clk);
    if (two) x2 <= 1'b1;
    else x1 <= 1'b1;
    @(posedge clk);
    {x1, x2} <= 2'b00;
  endtask
  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    n = $urandom(32'h1d2f);
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    apb(0, 8'h08, 0);
    chk(rd, 0);
    for (int i = 0; i < 4; i++) begin
      apb(0, 8'h10 + 8'($urandom % 60) * 4, 0);
      chk({er, rd}, 33'h100000000);
    end
    $display("test 1 done");
    d1 = $urandom % 2;
    run(cmd(0, d1, 1, 0, 0));
    chk(rd[4], d1);
    chk(u_dev.mon1_r, mreg(d1, 0, 1, 0, 1));
    chk({u_dev.en_r[7], u_dev.det_r[6], u_dev.osc_r[4]}, 3'b110);
    chk(u_dev.prot_r, 0);
    $display("test 2 done");
    apb(1, 8'h04, 1);
    pulse(0);
    n = 0;
    do begin
      apb(0, 8'h0C, 0);
      n++;
    end while (rd !== 1 && n < 200);
    chk(rd, 1);
    chk(u_dev.mon1_r, mreg(~d1, 0, 1, 0, 1));
    chk(irq1, 0);
    $display("test 3 done");
    apb(1, 8'h00, cmd(1, 0, 0, 0, 1) | 32'h40);
    repeat (1000) @(posedge clk);
    pulse(1);
    run(0);
    chk(rd[3], 1);
    chk({irq2, u_dev.mon2_r[0]}, 2'b01);
    chk(u_dev.mon2_r, mreg(0, 0, 0, 1, 1) | 32'h20);
    $display("test 4 done");
    run(cmd(1, 0, 1, 1, 0));
    chk(u_dev.mon2_r, mreg(1, 1, 1, 0, 1));
    pulse(1);
    repeat (3) @(posedge clk);
    chk(rreq, 1);
    apb(0, 8'h08, 0);
    chk(rd[6], 1);
    $display("test 5 done");
    report_and_stop;
  end
endmodule // supply_monitor_host_tb
